/* File: design/plc_pkg.sv */
// Package for the partition label level-3 control block.
// Assumes one 25 MHz clock and a synchronous active-low warm reset.
package plc_pkg;

  // Privilege level encodings
  localparam logic [1:0] LVL0 = 2'h0;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h2;
  localparam logic [1:0] LVL3 = 2'h3;

  // Level-1 label register encoding
  localparam logic [1:0] ENC_OP0 = 2'h3;
  localparam logic [2:0] ENC_OP1 = 3'h0;
  localparam logic [3:0] ENC_CRN = 4'hA;
  localparam logic [3:0] ENC_CRM = 4'h5;
  localparam logic [2:0] ENC_OP2 = 3'h0;
  // Level-3 label register encoding differs only in op1
  localparam logic [2:0] ENC_OP1_L3 = 3'h6;

  // Exception class for label register traps
  localparam logic [5:0] TRAP_CLASS = 6'h18;
  // Nested-virtualization memory offset
  localparam logic [11:0] NESTED_MEM_OFFSET = 12'h900;
  localparam logic [2:0] NESTED_ALL_SET = 3'h7;

  // Level-3 register field positions
  localparam int unsigned BIT_ENABLE = 63;
  localparam int unsigned BIT_TRAP_LOWER = 62;
  localparam int unsigned BIT_SEC_DEFAULT = 61;
  localparam int unsigned BIT_FORCE_NONSEC = 60;
  localparam int unsigned BIT_HIER_EN = 57;
  localparam int unsigned BIT_HIER_FORCE = 56;
  localparam int unsigned BIT_L3_SPACE = 55;

  // Reset values
  localparam logic RST_ENABLE = 1'h0;
  localparam logic RST_TRAP_LOWER = 1'h1;

  // Access outcome
  typedef enum logic [2:0]
  {
    ACT_NONE,
    ACT_UNDEF,
    ACT_TRAP_L3,
    ACT_TRAP_L2,
    ACT_NESTED_MEM,
    ACT_REG_L1,
    ACT_REG_L2,
    ACT_REG_L3
  } plc_action_type;

  // Access request from pipeline
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [1:0] level;
    logic [63:0] wdata;
  } plc_req_type;

  // Outcome returned to pipeline
  typedef struct packed
  {
    logic valid;
    plc_action_type action;
    logic [1:0] target_level;
    logic [5:0] exc_class;
    logic [11:0] mem_offset;
    logic [63:0] rdata;
  } plc_resp_type;

  // Level-3 control fields
  typedef struct packed
  {
    logic enable;
    logic trap_lower;
    logic sec_default;
    logic force_nonsec;
    logic hier_en;
    logic hier_force;
    logic l3_space;
  } plc_ctrl_type;

endpackage : plc_pkg

/* File: design/plc_decode.sv */
// Access decision for the level-1 and level-3 label register encodings.
// Assumes pipeline signals are in the same clock domain; purely combinational.
`timescale 1ns/1ns
module plc_decode
(
  input wire plc_pkg::plc_req_type req,
  input wire logic has_level3,
  input wire logic level2_enabled,
  input wire logic partition_present,
  input wire logic trap_lower,
  input wire logic trap_level1_label_access,
  input wire logic [2:0] nested_virt_bits,
  input wire logic host_extension_bit,
  input wire logic halted,
  input wire logic secure_debug_disable,
  output plc_pkg::plc_action_type action
);

  logic hit_l1;
  logic hit_l3;
  logic hit_common;

  // RL1: encoding decode
  assign hit_common = req.op0 == plc_pkg::ENC_OP0 && req.crn == plc_pkg::ENC_CRN &&
    req.crm == plc_pkg::ENC_CRM && req.op2 == plc_pkg::ENC_OP2;
  assign hit_l1 = hit_common && req.op1 == plc_pkg::ENC_OP1;
  assign hit_l3 = hit_common && req.op1 == plc_pkg::ENC_OP1_L3;

  // Priority tree mirrors the architectural access order
  always_comb
  begin
    action = plc_pkg::ACT_NONE;
    if (req.valid && hit_l3)
    begin
      // RL9: level-3 only, feature present
      action = (partition_present && req.level == plc_pkg::LVL3) ? plc_pkg::ACT_REG_L3 : plc_pkg::ACT_UNDEF;
    end
    else if (req.valid && hit_l1)
    begin
      if (!partition_present)
        action = plc_pkg::ACT_UNDEF;
      // RL2: level 0 undefined
      else if (req.level == plc_pkg::LVL0)
        action = plc_pkg::ACT_UNDEF;
      // RL8: level 3 direct
      else if (req.level == plc_pkg::LVL3)
        action = plc_pkg::ACT_REG_L1;
      // RL3: trap lower to level 3
      else if (has_level3 && trap_lower)
      begin
        // RL4: halted secure debug undef
        // RL12: lower levels forced trap
        action = (halted && secure_debug_disable) ? plc_pkg::ACT_UNDEF : plc_pkg::ACT_TRAP_L3;
      end
      else if (req.level == plc_pkg::LVL1)
      begin
        // RL5: trap to level 2
        if (level2_enabled && trap_level1_label_access)
          action = plc_pkg::ACT_TRAP_L2;
        // RL6: nested virtualization redirect
        else if (level2_enabled && nested_virt_bits == plc_pkg::NESTED_ALL_SET)
          action = plc_pkg::ACT_NESTED_MEM;
        else
          action = plc_pkg::ACT_REG_L1;
      end
      else
      begin
        // RL7: host extension alias
        action = host_extension_bit ? plc_pkg::ACT_REG_L2 : plc_pkg::ACT_REG_L1;
      end
    end
  end

endmodule : plc_decode

/* File: design/plc_top.sv */
// Level-3 partition label control register and label-register access gate.
// Assumes the pipeline presents one request per cycle and holds write data
// with it; level-1/level-2 register bodies outside are fed via write ports.
`timescale 1ns/1ns

// Functional notes
// RL1: Decode level-1 label encoding op0 3, op1 0, CRn 10, CRm 5, op2 0.
// RL2: Level-0 access to level-1 label register is undefined.
// RL3: Levels 1 and 2 trap to level 3 class 0x18 when trap-lower set.
// RL4: Halted with secure debug disable makes that trap undefined instead.
// RL5: Level 1 traps to level 2 when level-2 trap bit set.
// RL6: Level 1 nested bits 111 redirect to memory offset 0x900.
// RL7: Level 2 with host extension accesses level-2 register instead.
// RL8: Level 3 always accesses level-1 register directly.
// RL9: Level-3 register is 64 bits, undefined when feature absent.
// RL10: Bit 63 is one storage bit shared by all label registers.
// RL11: Enable 0 outputs default labels everywhere; resets to 0.
// RL12: Trap-lower forces lower-level direct accesses to level 3; resets 1.
// RL13: Secure-default forces partition and group zero in Secure state.
// RL14: Force-non-secure sets the non-secure label bit in Secure state.
// RL15: Force-non-secure may read as one if zero unsupported.
// RL16: Hierarchical enable lets level-2 space controls choose lower spaces.
// RL17: Hierarchical enable 0: force bit picks lower-level space.
// RL18: Level-3 space select picks primary or alternative for level 3.
// RL19: Hierarchical enable 1: level-2 select picks level-2 space.
// RL20: Reserved and unsupported fields read zero, ignore writes.
module plc_top
#(
  parameter bit HAS_LEVEL3 = 1'b1,
  parameter bit HAS_LEVEL2 = 1'b1,
  parameter bit PARTITION_PRESENT = 1'b1,
  parameter bit HAS_SEC_DEFAULT = 1'b1,
  parameter bit HAS_FORCE_NONSEC = 1'b1,
  parameter bit NS_ZERO_OK = 1'b1,
  parameter bit HAS_ALT_SPACE = 1'b1,
  parameter bit L3_SPACE_RESET = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire plc_pkg::plc_req_type req,
  output plc_pkg::plc_resp_type resp,
  input wire logic level2_enabled,
  input wire logic trap_level1_label_access,
  input wire logic [2:0] nested_virt_bits,
  input wire logic host_extension_bit,
  input wire logic halted,
  input wire logic secure_debug_disable,
  input wire logic [62:0] level1_label_low,
  input wire logic [62:0] level2_label_low,
  output logic level1_write,
  output logic level2_write,
  output logic [62:0] label_wdata_low,
  input wire logic secure_state,
  input wire logic [1:0] exec_level,
  input wire logic level2_space_select,
  output logic labels_enabled,
  output logic force_default_label,
  output logic nonsecure_label_bit,
  output logic level3_alt_space,
  output logic lower_alt_space,
  output logic level2_alt_space
);

  // Whole block state in one struct
  typedef struct packed
  {
    plc_pkg::plc_ctrl_type ctrl;
    plc_pkg::plc_resp_type resp;
    logic l1_wr;
    logic l2_wr;
    logic [62:0] wdata;
  } plc_state_type;

  plc_state_type st_q;
  plc_state_type st_d;
  plc_pkg::plc_action_type action;

  // Read image of the level-3 register, reserved bits zero
  function automatic logic [63:0] plc_l3_image(input plc_pkg::plc_ctrl_type c);
    logic [63:0] v;
    v = 64'h0;
    v[plc_pkg::BIT_ENABLE] = c.enable;
    v[plc_pkg::BIT_TRAP_LOWER] = c.trap_lower;
    v[plc_pkg::BIT_SEC_DEFAULT] = c.sec_default;
    v[plc_pkg::BIT_FORCE_NONSEC] = c.force_nonsec;
    v[plc_pkg::BIT_HIER_EN] = c.hier_en;
    v[plc_pkg::BIT_HIER_FORCE] = c.hier_force;
    v[plc_pkg::BIT_L3_SPACE] = c.l3_space;
    return v;
  endfunction : plc_l3_image

  plc_decode u_decode
  (
    .req(req),
    .has_level3(HAS_LEVEL3),
    .level2_enabled(level2_enabled),
    .partition_present(PARTITION_PRESENT),
    .trap_lower(st_q.ctrl.trap_lower),
    .trap_level1_label_access(trap_level1_label_access),
    .nested_virt_bits(nested_virt_bits),
    .host_extension_bit(host_extension_bit),
    .halted(halted),
    .secure_debug_disable(secure_debug_disable),
    .action(action)
  );

  // Next-state: register writes and registered response
  always_comb
  begin
    st_d = st_q;
    st_d.l1_wr = 1'b0;
    st_d.l2_wr = 1'b0;
    st_d.resp = '0;
    st_d.resp.valid = req.valid && action != plc_pkg::ACT_NONE;
    st_d.resp.action = action;
    unique case (action)
      plc_pkg::ACT_NONE,
      plc_pkg::ACT_UNDEF:
      begin
      end
      plc_pkg::ACT_TRAP_L3:
      begin
        // RL3: trap class to level 3
        st_d.resp.target_level = plc_pkg::LVL3;
        st_d.resp.exc_class = plc_pkg::TRAP_CLASS;
      end
      plc_pkg::ACT_TRAP_L2:
      begin
        // RL5: trap class to level 2
        st_d.resp.target_level = plc_pkg::LVL2;
        st_d.resp.exc_class = plc_pkg::TRAP_CLASS;
      end
      plc_pkg::ACT_NESTED_MEM:
      begin
        // RL6: memory offset handed back
        st_d.resp.mem_offset = plc_pkg::NESTED_MEM_OFFSET;
        st_d.resp.rdata = req.wdata;
      end
      plc_pkg::ACT_REG_L1,
      plc_pkg::ACT_REG_L2:
      begin
        // RL10: shared enable bit 63
        st_d.resp.rdata = {st_q.ctrl.enable,
          (action == plc_pkg::ACT_REG_L2) ? level2_label_low : level1_label_low};
        if (req.write)
        begin
          st_d.ctrl.enable = req.wdata[plc_pkg::BIT_ENABLE];
          st_d.wdata = req.wdata[62:0];
          // RL7: alias write to level 2
          st_d.l2_wr = action == plc_pkg::ACT_REG_L2 && HAS_LEVEL2;
          st_d.l1_wr = action == plc_pkg::ACT_REG_L1;
        end
      end
      plc_pkg::ACT_REG_L3:
      begin
        // RL9: level-3 register access
        st_d.resp.rdata = plc_l3_image(st_q.ctrl);
        if (req.write)
        begin
          st_d.ctrl.enable = req.wdata[plc_pkg::BIT_ENABLE];
          st_d.ctrl.trap_lower = req.wdata[plc_pkg::BIT_TRAP_LOWER];
          // RL20: unsupported fields stay zero
          st_d.ctrl.sec_default = HAS_SEC_DEFAULT & req.wdata[plc_pkg::BIT_SEC_DEFAULT];
          // RL15: read-as-one when zero impossible
          st_d.ctrl.force_nonsec = HAS_FORCE_NONSEC & (req.wdata[plc_pkg::BIT_FORCE_NONSEC] | ~NS_ZERO_OK);
          st_d.ctrl.hier_en = HAS_ALT_SPACE & req.wdata[plc_pkg::BIT_HIER_EN];
          st_d.ctrl.hier_force = HAS_ALT_SPACE & req.wdata[plc_pkg::BIT_HIER_FORCE];
          st_d.ctrl.l3_space = HAS_ALT_SPACE & req.wdata[plc_pkg::BIT_L3_SPACE];
        end
      end
    endcase
  end

  // Warm reset; optional fields given fixed values rather than unknown
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      // RL11: enable resets to 0
      st_q.ctrl.enable <= plc_pkg::RST_ENABLE;
      // RL12: trap-lower resets to 1
      st_q.ctrl.trap_lower <= plc_pkg::RST_TRAP_LOWER;
      st_q.ctrl.force_nonsec <= HAS_FORCE_NONSEC & ~NS_ZERO_OK;
      // RL18: implementation reset value
      st_q.ctrl.l3_space <= HAS_ALT_SPACE & L3_SPACE_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign resp = st_q.resp;
  assign level1_write = st_q.l1_wr;
  assign level2_write = st_q.l2_wr;
  assign label_wdata_low = st_q.wdata;

  // Label generation controls
  // RL11: default labels when disabled
  assign labels_enabled = st_q.ctrl.enable;
  // RL13: secure default forces zero
  assign force_default_label = !st_q.ctrl.enable || (secure_state && st_q.ctrl.sec_default);
  // RL14: non-secure bit in Secure state
  assign nonsecure_label_bit = secure_state ? st_q.ctrl.force_nonsec : 1'b1;
  // RL18: level-3 space
  assign level3_alt_space = exec_level == plc_pkg::LVL3 && st_q.ctrl.l3_space;
  // RL16: lower levels follow level-2 control when enabled
  // RL17: force bit rules otherwise
  assign lower_alt_space = st_q.ctrl.hier_en ? level2_space_select : st_q.ctrl.hier_force;
  // RL19: level-2 select under hierarchical enable
  assign level2_alt_space = st_q.ctrl.hier_en ? level2_space_select : st_q.ctrl.hier_force;

endmodule : plc_top

/* File: sim/plc_top_asserts.sv */
// Checker for the label control block, watching top-level ports only.
// Assumes one clock, clk_sys, and the synchronous reset rst_n.
`timescale 1ns/1ns
module plc_top_chk
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire plc_pkg::plc_req_type req,
  input wire plc_pkg::plc_resp_type resp,
  input wire logic level1_write,
  input wire logic level2_enabled,
  input wire logic trap_level1_label_access,
  input wire logic secure_state,
  input wire logic nonsecure_label_bit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic enc;
  // Common encoding fields; only op1 tells L1 and L3 apart
  assign enc = req.valid && req.op0 == 2'h3 && req.crn == 4'hA && req.crm == 4'h5 && req.op2 == 3'h0;
  refuse_other_a: assert property (req.valid && !(enc && (req.op1 == 3'h0 || req.op1 == 3'h6)) |=>
    !resp.valid) else $error("unmatched encoding answered");
  lvl0_undef_a: assert property (enc && req.op1 == 3'h0 && req.level == 2'h0 |=>
    resp.valid && resp.action == plc_pkg::ACT_UNDEF) else $error("level 0 access not undefined");
  l3_direct_a: assert property (enc && req.op1 == 3'h0 && req.level == 2'h3 |=>
    resp.valid && resp.action == plc_pkg::ACT_REG_L1) else $error("level 3 access redirected");
  trap_class_a: assert property (resp.valid && resp.action inside {plc_pkg::ACT_TRAP_L3, plc_pkg::ACT_TRAP_L2}
    |-> resp.exc_class == 6'h18) else $error("wrong trap class");
  l1_trap_a: assert property (enc && req.op1 == 3'h0 && req.level == 2'h1 && level2_enabled
    && trap_level1_label_access |=> resp.action inside {plc_pkg::ACT_TRAP_L3, plc_pkg::ACT_TRAP_L2,
    plc_pkg::ACT_UNDEF}) else $error("level 2 trap missed");
  nested_offset_a: assert property (resp.valid && resp.action == plc_pkg::ACT_NESTED_MEM
    |-> resp.mem_offset == 12'h900) else $error("wrong memory offset");
  l3_undef_a: assert property (enc && req.op1 == 3'h6 && req.level != 2'h3 |=>
    resp.valid && resp.action == plc_pkg::ACT_UNDEF) else $error("lower level reached L3 register");
  wr_cause_a: assert property (level1_write |-> $past(req.valid && req.write))
    else $error("write pulse without write");
  ns_out_a: assert property (!secure_state |-> nonsecure_label_bit)
    else $error("non-secure bit low outside Secure");
endmodule : plc_top_chk

bind plc_top plc_top_chk plc_top_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .resp(resp),
  .level1_write(level1_write), .level2_enabled(level2_enabled),
  .trap_level1_label_access(trap_level1_label_access), .secure_state(secure_state),
  .nonsecure_label_bit(nonsecure_label_bit));

/* File: sim/plc_pipe_model.sv */
// Pipeline model issuing label register accesses.
// Assumes requests are taken at the rising edge of clk_sys.
`timescale 1ns/1ns
module plc_pipe_model
(
  input wire logic clk_sys,
  output plc_pkg::plc_req_type req,
  input wire plc_pkg::plc_resp_type resp
);
  initial req = '0;
  // Request held across its taking edge, answer read one cycle later
  task automatic issue(input logic [1:0] lv, input logic w, input logic [2:0] o1, input logic [63:0] d,
    output plc_pkg::plc_resp_type r);
    @(negedge clk_sys);
    req <= {1'b1, w, 2'h3, o1, 4'hA, 4'h5, 3'h0, lv, d};
    @(negedge clk_sys);
    r = resp;
    req.valid <= 1'b0;
    req.wdata <= ~d; // Stale data never looks valid
  endtask : issue
endmodule : plc_pipe_model

/* File: sim/tb.sv */
// Self-checking bench for the label control block.
// Assumes the pipeline model drives req; other inputs are set here.
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic l2en = 1'b0, trp = 1'b0, hx = 1'b0, hlt = 1'b0, sdbg = 1'b0, sec = 1'b0, l2sel = 1'b0;
  logic [2:0] nest = 3'h0;
  logic [1:0] el = 2'h0;
  int mismatches = 0;
  int cmp_count = 0;
  plc_pkg::plc_req_type req;
  plc_pkg::plc_resp_type resp, r;
  logic l1w, l2w, labs, fdef, nsb, l3alt, lalt, l2alt;
  logic [62:0] lwd;
  plc_pipe_model plc_pipe_model_i (.clk_sys(clk_sys), .req(req), .resp(resp));
  plc_top plc_top_i
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .resp(resp), .level2_enabled(l2en),
    .trap_level1_label_access(trp), .nested_virt_bits(nest), .host_extension_bit(hx), .halted(hlt),
    .secure_debug_disable(sdbg), .level1_label_low(63'h5), .level2_label_low(63'hA), .level1_write(l1w),
    .level2_write(l2w), .label_wdata_low(lwd), .secure_state(sec), .exec_level(el), .level2_space_select(l2sel),
    .labels_enabled(labs), .force_default_label(fdef), .nonsecure_label_bit(nsb),
    .level3_alt_space(l3alt), .lower_alt_space(lalt), .level2_alt_space(l2alt)
  );
  // 25 MHz clock
  initial forever #20 clk_sys = ~clk_sys;
  task automatic rst;
    rst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
  endtask : rst
  // One access and a check of its outcome
  task automatic ex(input logic [1:0] lv, input logic [2:0] o1, input logic w, input logic [63:0] d,
    input plc_pkg::plc_action_type a);
    plc_pipe_model_i.issue(lv, w, o1, d, r);
    `CHK("action", a, r.action)
  endtask : ex
  task automatic results;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    results();
  end
  // Main sequence; every read of L3 is made at level 3 except one level-2 read that must be undefined
  initial
  begin
    rst();
    ex(2'h3, 3'h6, 1'b0, 64'h0, plc_pkg::ACT_REG_L3);
    `CHK("l3 reset", 64'h4000_0000_0000_0000, r.rdata)
    `CHK("enable", 1'b0, labs)
    ex(2'h0, 3'h0, 1'b0, 64'h0, plc_pkg::ACT_UNDEF);
    ex(2'h1, 3'h0, 1'b1, 64'h0, plc_pkg::ACT_TRAP_L3);
    `CHK("class", 6'h18, r.exc_class)
    `CHK("target", 2'h3, r.target_level)
    ex(2'h2, 3'h0, 1'b0, 64'h0, plc_pkg::ACT_TRAP_L3);
    hlt = 1'b1;
    sdbg = 1'b1;
    ex(2'h1, 3'h0, 1'b0, 64'h0, plc_pkg::ACT_UNDEF);
    hlt = 1'b0;
    ex(2'h2, 3'h6, 1'b0, 64'h0, plc_pkg::ACT_UNDEF);
    sec = 1'b1;
    // Level-3 space output only follows the select while running at level 3
    el = 2'h3;
    ex(2'h3, 3'h6, 1'b1, '1, plc_pkg::ACT_REG_L3);
    ex(2'h3, 3'h6, 1'b0, 64'h0, plc_pkg::ACT_REG_L3);
    `CHK("l3 all", 64'hF380_0000_0000_0000, r.rdata)
    `CHK("enable", 1'b1, labs)
    `CHK("default", 1'b1, fdef)
    `CHK("ns", 1'b1, nsb)
    `CHK("l3 space", 1'b1, l3alt)
    `CHK("l2 space", 1'b0, l2alt)
    `CHK("low space", 1'b0, lalt)
    // Hierarchy off, force on, trap-lower cleared
    ex(2'h3, 3'h6, 1'b1, 64'h8100_0000_0000_0000, plc_pkg::ACT_REG_L3);
    `CHK("default", 1'b0, fdef)
    `CHK("ns", 1'b0, nsb)
    `CHK("l3 space", 1'b0, l3alt)
    `CHK("low space", 1'b1, lalt)
    `CHK("l2 space", 1'b1, l2alt)
    l2en = 1'b1;
    trp = 1'b1;
    ex(2'h1, 3'h0, 1'b0, 64'h0, plc_pkg::ACT_TRAP_L2);
    `CHK("target", 2'h2, r.target_level)
    trp = 1'b0;
    nest = 3'h7;
    ex(2'h1, 3'h0, 1'b1, 64'h1, plc_pkg::ACT_NESTED_MEM);
    `CHK("offset", 12'h900, r.mem_offset)
    `CHK("l1 write", 1'b0, l1w)
    nest = 3'h0;
    // Alias write clears the shared enable, seen next through the level-1 view
    hx = 1'b1;
    ex(2'h2, 3'h0, 1'b1, 64'h3, plc_pkg::ACT_REG_L2);
    `CHK("alias data", 64'h8000_0000_0000_000A, r.rdata)
    `CHK("l2 write", 1'b1, l2w)
    `CHK("l1 write", 1'b0, l1w)
    `CHK("l2 data", 63'h3, lwd)
    hx = 1'b0;
    ex(2'h2, 3'h0, 1'b0, 64'h0, plc_pkg::ACT_REG_L1);
    `CHK("l1 view", 64'h5, r.rdata)
    ex(2'h3, 3'h0, 1'b1, 64'hA5, plc_pkg::ACT_REG_L1);
    `CHK("l1 write", 1'b1, l1w)
    `CHK("l1 data", 63'hA5, lwd)
    ex(2'h3, 3'h6, 1'b0, 64'h0, plc_pkg::ACT_REG_L3);
    `CHK("shared", 64'h0100_0000_0000_0000, r.rdata)
    `CHK("enable", 1'b0, labs)
    plc_pipe_model_i.issue(2'h3, 1'b0, 3'h2, 64'h0, r);
    `CHK("refused", 1'b0, r.valid)
    rst();
    ex(2'h3, 3'h6, 1'b0, 64'h0, plc_pkg::ACT_REG_L3);
    `CHK("l3 reset", 64'h4000_0000_0000_0000, r.rdata)
    results();
  end
endmodule : tb
